/* File: logic/pmp_midi_core.sv */
// MIDI message core: transmit gating, program change remapping and keyboard pattern entry.
// Assumes parsed, single-cycle MIDI messages and panel events, all on clk.
`timescale 1ns/1ps

// Operation
// RQ1 - Program and bank messages go out on selection only while program transmit is on.
// RQ2 - Panel controller messages go out only while controller transmit is on.
// RQ3 - Bank select and modulation wheel controllers bypass the controller transmit switch.
// RQ4 - Bank value 0 on controller 32 starts remapping for that channel.
// RQ5 - Map holds one viewable, editable entry for every program number 0 to 127.
// RQ6 - Every channel remaps after reset until it gets a valid bank select.
// RQ7 - A received valid bank stays selected until another bank select arrives.
// RQ8 - A program or performance bank ends remapping; programs then address it.
// RQ9 - Map mode applies the map to every program change whatever banks came.
// RQ10 - Map targets are seven kinds, each with an item number.
// RQ11 - Map and pattern edits are stored only on write with protection off.
// RQ12 - With keyboard entry off, notes never change pattern steps.
// RQ13 - Keyboard note-on stores note and velocity; its note-off advances the step.
// RQ14 - Sustain press with no note held writes a rest.
// RQ15 - Sustain press with a note held marks glide; release then advances.
// RQ16 - Entry mode is off, on, note only, velocity only or gate only.
// RQ17 - Notes and sustain for pattern entry are taken on any channel.
// RQ18 - User patterns below 64 are mono, 64 to 127 poly.
// RQ19 - Step count is 1 to 64 and the step index stays below it.
// RQ20 - Step notes are 1 to 12 mono, -36 to +36 poly.
// RQ21 - Step gate is normal, tie, rest or glide.
// RQ22 - Note editable only on normal or glide steps; velocity 1 to 127.
module pmp_midi_core #(
    parameter int CHANNELS = 16,
    parameter int MAX_STEPS = 64
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic prog_tx_enable,
    input wire logic ctrl_tx_enable,
    input wire logic panel_sel_valid,
    input wire logic [3:0] panel_sel_chan,
    input wire logic [6:0] panel_sel_bank,
    input wire logic [6:0] panel_sel_prog,
    input wire logic panel_cc_valid,
    input wire pmp_pkg::pmp_cc_kind_t panel_cc_kind,
    input wire logic [3:0] panel_cc_chan,
    input wire logic [6:0] panel_cc_num,
    input wire logic [6:0] panel_cc_val,
    output logic tx_pc_valid,
    output logic tx_bank_valid,
    output logic [3:0] tx_chan,
    output logic [6:0] tx_prog,
    output logic [6:0] tx_bank,
    output logic tx_cc_valid,
    output logic [3:0] tx_cc_chan,
    output logic [6:0] tx_cc_num,
    output logic [6:0] tx_cc_val,
    input wire logic rx_valid,
    input wire pmp_pkg::pmp_rx_kind_t rx_kind,
    input wire logic [3:0] rx_chan,
    input wire logic [6:0] rx_d1,
    input wire logic [6:0] rx_d2,
    input wire pmp_pkg::pmp_pc_mode_t incoming_pc_mode,
    output logic sel_valid,
    output logic [3:0] sel_chan,
    output pmp_pkg::pmp_target_t sel_target,
    output logic [6:0] sel_item,
    input wire logic [6:0] map_edit_idx,
    input wire pmp_pkg::pmp_target_t map_edit_target,
    input wire logic [6:0] map_edit_item,
    input wire logic map_edit_we,
    output pmp_pkg::pmp_target_t map_view_target,
    output logic [6:0] map_view_item,
    input wire logic map_page_active,
    input wire logic pattern_page_active,
    input wire logic write_button,
    input wire logic memory_protect,
    input wire pmp_pkg::pmp_kpe_t keyboard_pattern_entry_mode,
    input wire logic [6:0] user_pattern,
    input wire logic [6:0] pattern_step_count,
    input wire logic panel_step_we,
    input wire pmp_pkg::pmp_field_t panel_field,
    input wire logic [6:0] panel_value,
    output logic [5:0] step_ptr,
    output pmp_pkg::pmp_gate_t step_gate,
    output logic signed [6:0] step_note,
    output logic [6:0] step_vel,
    output logic pattern_poly,
    output logic pattern_commit
);

    if (CHANNELS != pmp_pkg::PMP_CHANNELS || MAX_STEPS != pmp_pkg::PMP_MAX_STEPS) begin : g_chk
        $error("pmp_midi_core serves 16 channels and 64 steps only");
    end

    typedef struct packed {
        logic [CHANNELS-1:0] rmap;
        logic [CHANNELS-1:0][6:0] bank;
        logic held;
        logic [6:0] held_note;
        logic sus;
        logic [5:0] ptr;
        logic [6:0] cnt;
        logic poly;
        pmp_pkg::pmp_step_t [MAX_STEPS-1:0] steps;
        logic pc_v;
        logic [3:0] tx_ch;
        logic [6:0] tx_prog;
        logic [6:0] tx_bank;
        logic cc_v;
        logic [3:0] cc_ch;
        logic [6:0] cc_num;
        logic [6:0] cc_val;
        logic sel_v;
        logic [3:0] sel_ch;
        pmp_pkg::pmp_target_t sel_tgt;
        logic [6:0] sel_item;
        logic commit;
    } pmp_core_st_t;

    pmp_core_st_t q, d;
    pmp_map_if map ();

    pmp_remap_table u_table (
        .clk(clk),
        .reset_n(reset_n),
        .map(map)
    );

    // RQ20 keyboard note to step note
    function automatic logic signed [6:0] pmp_kbd_note(input logic [6:0] n, input logic poly);
        logic signed [8:0] rel;
        rel = $signed({2'b00, n}) - pmp_pkg::PMP_POLY_CENTER;
        if (!poly) begin
            return $signed(7'(n % pmp_pkg::PMP_OCTAVE)) + pmp_pkg::PMP_MONO_MIN;
        end
        if (rel < pmp_pkg::PMP_POLY_MIN) begin
            rel = pmp_pkg::PMP_POLY_MIN;
        end else if (rel > pmp_pkg::PMP_POLY_MAX) begin
            rel = pmp_pkg::PMP_POLY_MAX;
        end
        return 7'(rel);
    endfunction

    // RQ20 panel note clamp
    function automatic logic signed [6:0] pmp_fit_note(input logic signed [6:0] v, input logic poly);
        logic signed [8:0] w;
        w = 9'(v);
        if (!poly) begin
            if (v < pmp_pkg::PMP_MONO_MIN) begin
                return pmp_pkg::PMP_MONO_MIN;
            end
            return (v > pmp_pkg::PMP_MONO_MAX) ? pmp_pkg::PMP_MONO_MAX : v;
        end
        if (w < pmp_pkg::PMP_POLY_MIN) begin
            w = pmp_pkg::PMP_POLY_MIN;
        end else if (w > pmp_pkg::PMP_POLY_MAX) begin
            w = pmp_pkg::PMP_POLY_MAX;
        end
        return 7'(w);
    endfunction

    logic is_cc, note_on, note_off, sus_press, kbd, kbd_evt, adv, gate_w, note_w, vel_w;
    logic [6:0] nxt;
    pmp_pkg::pmp_step_t st;

    assign is_cc = rx_valid && rx_kind == pmp_pkg::PMP_RX_CC;
    // RQ17 any channel
    assign note_on = rx_valid && rx_kind == pmp_pkg::PMP_RX_NOTE_ON && rx_d2 != 7'h00;
    assign note_off = rx_valid && (rx_kind == pmp_pkg::PMP_RX_NOTE_OFF
                      || (rx_kind == pmp_pkg::PMP_RX_NOTE_ON && rx_d2 == 7'h00));
    assign sus_press = is_cc && rx_d1 == pmp_pkg::PMP_CC_SUSTAIN && rx_d2 >= pmp_pkg::PMP_SUSTAIN_ON && !q.sus;
    // RQ12 entry gated by mode
    assign kbd = keyboard_pattern_entry_mode != pmp_pkg::PMP_KPE_OFF && pattern_page_active;
    assign kbd_evt = kbd && (note_on || note_off || sus_press);
    // RQ16 partial modes limit fields
    assign gate_w = keyboard_pattern_entry_mode inside {pmp_pkg::PMP_KPE_ON, pmp_pkg::PMP_KPE_GATE};
    assign note_w = keyboard_pattern_entry_mode inside {pmp_pkg::PMP_KPE_ON, pmp_pkg::PMP_KPE_NOTE};
    assign vel_w = keyboard_pattern_entry_mode inside {pmp_pkg::PMP_KPE_ON, pmp_pkg::PMP_KPE_VEL};

    assign map.look_idx = rx_d1;
    assign map.view_idx = map_edit_idx;
    // RQ10 target kind and item
    assign map.edit_ent = '{tgt: map_edit_target, item: map_edit_item};
    assign map.edit_we = map_edit_we;
    // RQ11 map write qualified
    assign map.commit = write_button && !memory_protect && map_page_active;

    always_comb begin
        d = q;
        adv = 1'b0;
        st = q.steps[q.ptr];
        nxt = {1'b0, q.ptr} + 7'h01;
        d.pc_v = 1'b0;
        d.cc_v = 1'b0;
        d.sel_v = 1'b0;
        // RQ1 program transmit gate
        if (panel_sel_valid && prog_tx_enable) begin
            d.pc_v = 1'b1;
            d.tx_ch = panel_sel_chan;
            d.tx_prog = panel_sel_prog;
            d.tx_bank = panel_sel_bank;
        end
        // RQ2 controller transmit gate
        // RQ3 bank and modwheel exempt
        if (panel_cc_valid && (ctrl_tx_enable || panel_cc_kind != pmp_pkg::PMP_CCK_PANEL)) begin
            d.cc_v = 1'b1;
            d.cc_ch = panel_cc_chan;
            d.cc_num = panel_cc_num;
            d.cc_val = panel_cc_val;
        end
        if (is_cc && rx_d1 == pmp_pkg::PMP_CC_BANK_LSB && incoming_pc_mode != pmp_pkg::PMP_PC_DISABLED) begin
            // RQ4 bank 0 enters remap
            if (rx_d2 == pmp_pkg::PMP_BANK_MAP) begin
                d.rmap[rx_chan] = 1'b1;
            // RQ8 real bank leaves remap
            // RQ7 bank held per channel
            end else if (rx_d2 inside {pmp_pkg::PMP_BANK_PROG_A, pmp_pkg::PMP_BANK_PROG_B,
                                       pmp_pkg::PMP_BANK_PERF_A}) begin
                d.rmap[rx_chan] = 1'b0;
                d.bank[rx_chan] = rx_d2;
            end
        end
        if (rx_valid && rx_kind == pmp_pkg::PMP_RX_PC && incoming_pc_mode != pmp_pkg::PMP_PC_DISABLED) begin
            d.sel_v = 1'b1;
            d.sel_ch = rx_chan;
            // RQ9 map mode always maps
            // RQ4 remap through table
            if (incoming_pc_mode == pmp_pkg::PMP_PC_MAP || q.rmap[rx_chan]) begin
                d.sel_tgt = map.look_ent.tgt;
                d.sel_item = map.look_ent.item;
            end else begin
                d.sel_item = rx_d1;
                unique case (q.bank[rx_chan])
                    pmp_pkg::PMP_BANK_PROG_A: d.sel_tgt = pmp_pkg::PMP_TGT_PROG_A;
                    pmp_pkg::PMP_BANK_PROG_B: d.sel_tgt = pmp_pkg::PMP_TGT_PROG_B;
                    default: d.sel_tgt = pmp_pkg::PMP_TGT_PERF_A;
                endcase
            end
        end
        if (is_cc && rx_d1 == pmp_pkg::PMP_CC_SUSTAIN) begin
            d.sus = rx_d2 >= pmp_pkg::PMP_SUSTAIN_ON;
        end
        if (kbd_evt) begin
            if (note_on && !q.held) begin
                // RQ13 note-on fills step
                d.held = 1'b1;
                d.held_note = rx_d1;
                if (gate_w) begin
                    st.gate = pmp_pkg::PMP_GATE_NORM;
                end
                // RQ22 note only on norm or glide
                if (note_w && st.gate inside {pmp_pkg::PMP_GATE_NORM, pmp_pkg::PMP_GATE_GLIDE}) begin
                    st.note = pmp_kbd_note(rx_d1, q.poly);
                end
                if (vel_w) begin
                    st.vel = rx_d2;
                end
            end else if (note_off && q.held && rx_d1 == q.held_note) begin
                // RQ13 note-off advances
                d.held = 1'b0;
                adv = 1'b1;
            end else if (sus_press) begin
                // RQ14 rest when idle
                // RQ15 glide when held
                if (gate_w) begin
                    st.gate = q.held ? pmp_pkg::PMP_GATE_GLIDE : pmp_pkg::PMP_GATE_REST;
                end
                adv = !q.held;
            end
            d.steps[q.ptr] = st;
        end else if (panel_step_we) begin
            unique case (panel_field)
                pmp_pkg::PMP_FLD_STEP: d.ptr = panel_value[5:0];
                pmp_pkg::PMP_FLD_NOTE: begin
                    // RQ22 note locked on tie or rest
                    if (st.gate inside {pmp_pkg::PMP_GATE_NORM, pmp_pkg::PMP_GATE_GLIDE}) begin
                        st.note = pmp_fit_note($signed(panel_value), q.poly);
                    end
                end
                // RQ22 velocity floor
                pmp_pkg::PMP_FLD_VEL: st.vel = (panel_value < pmp_pkg::PMP_VEL_MIN) ?
                    pmp_pkg::PMP_VEL_MIN : panel_value;
                // RQ21 four gate kinds
                pmp_pkg::PMP_FLD_GATE: st.gate = pmp_pkg::pmp_gate_t'(panel_value[1:0]);
            endcase
            d.steps[q.ptr] = st;
        end
        if (!kbd) begin
            d.held = 1'b0;
        end
        // RQ19 count limits
        if (pattern_step_count < pmp_pkg::PMP_COUNT_MIN) begin
            d.cnt = pmp_pkg::PMP_COUNT_MIN;
        end else if (pattern_step_count > pmp_pkg::PMP_COUNT_MAX) begin
            d.cnt = pmp_pkg::PMP_COUNT_MAX;
        end else begin
            d.cnt = pattern_step_count;
        end
        if (adv) begin
            d.ptr = (nxt >= q.cnt) ? 6'h00 : nxt[5:0];
        end
        // RQ19 index below count
        if ({1'b0, d.ptr} >= d.cnt) begin
            d.ptr = 6'(d.cnt - 7'h01);
        end
        // RQ18 poly from pattern number
        d.poly = user_pattern >= pmp_pkg::PMP_POLY_FIRST;
        // RQ11 pattern write qualified
        d.commit = write_button && !memory_protect && pattern_page_active;
        // RQ6 remap after reset
        if (!reset_n) begin
            d = '0;
            d.rmap = '1;
            d.cnt = pmp_pkg::PMP_COUNT_MIN;
            for (int i = 0; i < MAX_STEPS; i++) begin
                d.steps[i] = '{gate: pmp_pkg::PMP_GATE_NORM, note: pmp_pkg::PMP_MONO_MIN,
                               vel: pmp_pkg::PMP_VEL_RESET};
            end
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign tx_pc_valid = q.pc_v;
    assign tx_bank_valid = q.pc_v;
    assign tx_chan = q.tx_ch;
    assign tx_prog = q.tx_prog;
    assign tx_bank = q.tx_bank;
    assign tx_cc_valid = q.cc_v;
    assign tx_cc_chan = q.cc_ch;
    assign tx_cc_num = q.cc_num;
    assign tx_cc_val = q.cc_val;
    assign sel_valid = q.sel_v;
    assign sel_chan = q.sel_ch;
    assign sel_target = q.sel_tgt;
    assign sel_item = q.sel_item;
    assign map_view_target = map.view_ent.tgt;
    assign map_view_item = map.view_ent.item;
    assign step_ptr = q.ptr;
    assign step_gate = q.steps[q.ptr].gate;
    assign step_note = q.steps[q.ptr].note;
    assign step_vel = q.steps[q.ptr].vel;
    assign pattern_poly = q.poly;
    assign pattern_commit = q.commit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    prog_tx_gate_a: assert property (panel_sel_valid && !prog_tx_enable |=> !tx_pc_valid) // RQ1
        else $error("program change sent while disabled");
    prog_tx_send_a: assert property (panel_sel_valid && prog_tx_enable
        |=> tx_pc_valid && tx_bank_valid && tx_prog == $past(panel_sel_prog)) // RQ1
        else $error("program change not sent");
    cc_tx_gate_a: assert property (panel_cc_valid && panel_cc_kind == pmp_pkg::PMP_CCK_PANEL
        |=> tx_cc_valid == $past(ctrl_tx_enable)) // RQ2
        else $error("controller gating wrong");
    cc_exempt_send_a: assert property (panel_cc_valid && panel_cc_kind != pmp_pkg::PMP_CCK_PANEL
        |=> tx_cc_valid && tx_cc_val == $past(panel_cc_val)) // RQ3
        else $error("bank or modwheel controller suppressed");
    map_enter_a: assert property (is_cc && rx_d1 == pmp_pkg::PMP_CC_BANK_LSB && rx_d2 == pmp_pkg::PMP_BANK_MAP
        && incoming_pc_mode != pmp_pkg::PMP_PC_DISABLED |=> q.rmap[$past(rx_chan)]) // RQ4
        else $error("bank 0 did not enter remap");
    map_leave_a: assert property (is_cc && rx_d1 == pmp_pkg::PMP_CC_BANK_LSB && rx_d2 == pmp_pkg::PMP_BANK_PROG_B
        && incoming_pc_mode != pmp_pkg::PMP_PC_DISABLED ##1 !rx_valid ##1 rx_valid && rx_kind == pmp_pkg::PMP_RX_PC
        && rx_chan == $past(rx_chan, 2) && incoming_pc_mode == pmp_pkg::PMP_PC_ENABLED
        |=> sel_valid && sel_target == pmp_pkg::PMP_TGT_PROG_B) // RQ8
        else $error("bank select did not leave remap");
    map_always_a: assert property (rx_valid && rx_kind == pmp_pkg::PMP_RX_PC && incoming_pc_mode == pmp_pkg::PMP_PC_MAP
        |=> sel_valid && sel_item == $past(map.look_ent.item)) // RQ9
        else $error("map mode did not use the map");
    kbd_off_hold_a: assert property (keyboard_pattern_entry_mode == pmp_pkg::PMP_KPE_OFF && !panel_step_we
        |=> $stable(q.steps)) // RQ12
        else $error("pattern changed with entry off");
    note_off_step_a: assert property (kbd && note_off && q.held && rx_d1 == q.held_note && q.cnt > 7'h01
        && {1'b0, q.ptr} + 7'h01 < q.cnt && pattern_step_count == q.cnt |=> step_ptr == $past(q.ptr) + 6'h01) // RQ13
        else $error("note-off did not advance the step");
    step_bound_a: assert property ({1'b0, step_ptr} < q.cnt && q.cnt <= pmp_pkg::PMP_COUNT_MAX) // RQ19
        else $error("step index beyond step count");
    vel_floor_a: assert property (step_vel >= pmp_pkg::PMP_VEL_MIN) // RQ22
        else $error("step velocity below one");

    remap_pc_c: cover property (q.rmap[rx_chan] && rx_valid && rx_kind == pmp_pkg::PMP_RX_PC ##1 sel_valid);
    glide_c: cover property (kbd && sus_press && q.held ##[1:20] kbd && note_off);
    rest_c: cover property (kbd && sus_press && !q.held && gate_w);
    wrap_c: cover property (step_ptr != 6'h00 ##1 step_ptr == 6'h00);

endmodule // pmp_midi_core

/* File: logic/pmp_pkg.sv */
// Shared types and constants for the MIDI program map and pattern entry block.
// Assumes MIDI bytes are already parsed into messages by a receiver outside.
package pmp_pkg;

    localparam int PMP_CHANNELS = 16;
    localparam int PMP_MAP_ENTRIES = 128;
    localparam int PMP_MAX_STEPS = 64;

    // Controller numbers and the sustain on level seen on the link
    localparam logic [6:0] PMP_CC_BANK_LSB = 7'h20;
    localparam logic [6:0] PMP_CC_SUSTAIN = 7'h40;
    localparam logic [6:0] PMP_SUSTAIN_ON = 7'h40;

    // Bank values on controller 32
    localparam logic [6:0] PMP_BANK_MAP = 7'h00;
    localparam logic [6:0] PMP_BANK_PROG_A = 7'h01;
    localparam logic [6:0] PMP_BANK_PROG_B = 7'h02;
    localparam logic [6:0] PMP_BANK_PERF_A = 7'h03;

    // Note and velocity values of a step, poly pattern threshold and step count limits
    localparam logic signed [6:0] PMP_MONO_MIN = 7'sh01;
    localparam logic signed [6:0] PMP_MONO_MAX = 7'sh0c;
    localparam logic [6:0] PMP_OCTAVE = 7'h0c;
    localparam logic signed [8:0] PMP_POLY_MIN = -9'sh024;
    localparam logic signed [8:0] PMP_POLY_MAX = 9'sh024;
    localparam logic signed [8:0] PMP_POLY_CENTER = 9'sh03c;
    localparam logic [6:0] PMP_VEL_MIN = 7'h01;
    localparam logic [6:0] PMP_VEL_RESET = 7'h40;
    localparam logic [6:0] PMP_POLY_FIRST = 7'h40;
    localparam logic [6:0] PMP_COUNT_MIN = 7'h01;
    localparam logic [6:0] PMP_COUNT_MAX = 7'h40;

    typedef enum logic [2:0] {
        PMP_KPE_OFF = 3'b000,
        PMP_KPE_ON = 3'b001,
        PMP_KPE_NOTE = 3'b010,
        PMP_KPE_VEL = 3'b011,
        PMP_KPE_GATE = 3'b100
    } pmp_kpe_t;

    typedef enum logic [1:0] {
        PMP_GATE_NORM = 2'b00,
        PMP_GATE_TIE = 2'b01,
        PMP_GATE_REST = 2'b10,
        PMP_GATE_GLIDE = 2'b11
    } pmp_gate_t;

    typedef enum logic [2:0] {
        PMP_TGT_CURR = 3'b000,
        PMP_TGT_PROG_A = 3'b001,
        PMP_TGT_PROG_B = 3'b010,
        PMP_TGT_PERF_A = 3'b011,
        PMP_TGT_ARP_M = 3'b100,
        PMP_TGT_ARP_P = 3'b101,
        PMP_TGT_ARP_U = 3'b110
    } pmp_target_t;

    typedef enum logic [1:0] {
        PMP_PC_DISABLED = 2'b00,
        PMP_PC_ENABLED = 2'b01,
        PMP_PC_MAP = 2'b10
    } pmp_pc_mode_t;

    typedef enum logic [1:0] {
        PMP_RX_NOTE_ON = 2'b00,
        PMP_RX_NOTE_OFF = 2'b01,
        PMP_RX_CC = 2'b10,
        PMP_RX_PC = 2'b11
    } pmp_rx_kind_t;

    typedef enum logic [1:0] {
        PMP_CCK_PANEL = 2'b00,
        PMP_CCK_BANK = 2'b01,
        PMP_CCK_MODWHEEL = 2'b10
    } pmp_cc_kind_t;

    typedef enum logic [1:0] {
        PMP_FLD_STEP = 2'b00,
        PMP_FLD_NOTE = 2'b01,
        PMP_FLD_VEL = 2'b10,
        PMP_FLD_GATE = 2'b11
    } pmp_field_t;

    typedef struct packed {
        pmp_gate_t gate;
        logic signed [6:0] note;
        logic [6:0] vel;
    } pmp_step_t;

    typedef struct packed {
        pmp_target_t tgt;
        logic [6:0] item;
    } pmp_map_entry_t;

endpackage

/* File: logic/pmp_map_if.sv */
// Link between the message core and the program map table.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pmp_map_if;
    logic [6:0] look_idx;
    pmp_pkg::pmp_map_entry_t look_ent;
    logic [6:0] view_idx;
    pmp_pkg::pmp_map_entry_t view_ent;
    pmp_pkg::pmp_map_entry_t edit_ent;
    logic edit_we;
    logic commit;

    modport core (output look_idx, output view_idx, output edit_ent, output edit_we, output commit,
                  input look_ent, input view_ent);
    modport store (input look_idx, input view_idx, input edit_ent, input edit_we, input commit,
                   output look_ent, output view_ent);
endinterface

/* File: logic/pmp_remap_table.sv */
// Program map table: an edit copy and a stored copy, one entry per program number.
// Assumes the core qualifies commit with the write button and memory protection.
`timescale 1ns/1ps
module pmp_remap_table (
    input wire logic clk,
    input wire logic reset_n,
    pmp_map_if.store map
);

    typedef struct packed {
        pmp_pkg::pmp_map_entry_t [pmp_pkg::PMP_MAP_ENTRIES-1:0] work;
        pmp_pkg::pmp_map_entry_t [pmp_pkg::PMP_MAP_ENTRIES-1:0] saved;
    } pmp_table_st_t;

    pmp_table_st_t q, d;

    always_comb begin
        d = q;
        if (map.edit_we) begin
            d.work[map.view_idx] = map.edit_ent;
        end
        // RQ11 store on write
        if (map.commit) begin
            d.saved = d.work;
        end
        // RQ5 one entry each
        if (!reset_n) begin
            for (int i = 0; i < pmp_pkg::PMP_MAP_ENTRIES; i++) begin
                d.work[i] = '{tgt: pmp_pkg::PMP_TGT_CURR, item: 7'(i)};
                d.saved[i] = '{tgt: pmp_pkg::PMP_TGT_CURR, item: 7'(i)};
            end
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // Incoming program changes follow the stored map; edits show only on the view port
    assign map.look_ent = q.saved[map.look_idx];
    assign map.view_ent = q.work[map.view_idx];

    // RQ11 commit copies edits
    commit_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
        map.commit && !map.edit_we |=> q.saved[$past(map.view_idx)] == $past(q.work[map.view_idx]))
        else $error("stored map entry not taken from edit copy");

endmodule // pmp_remap_table

/* File: dv/pmp_kbd_model.sv */
// Keyboard side: turns a bench request into one parsed MIDI message.
// Assumes requests are raised after a falling edge and held one cycle.
`timescale 1ns/1ps
module pmp_kbd_model (
    input wire logic go,
    input wire logic [19:0] msg,
    output logic rx_valid,
    output logic [19:0] rx_msg
);
    assign rx_valid = go;
    // Idle lines show the inverse so a stale message never looks valid
    assign rx_msg = go ? msg : ~msg;
endmodule // pmp_kbd_model

/* File: dv/pmp_midi_core_tb_top.sv */
// Bench for the MIDI core: transmit gating, program remap, keyboard entry, commit.
// Assumes a 10 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module pmp_midi_core_tb_top;
    logic clk = 0, reset_n = 0, prog_tx_enable = 1, ctrl_tx_enable = 0, panel_sel_valid = 0, panel_cc_valid = 0;
    logic map_edit_we = 0, map_page_active = 0, pattern_page_active = 0, write_button = 0, memory_protect = 0;
    logic panel_step_we = 0, go = 0, rx_valid, tx_pc_valid, tx_bank_valid, tx_cc_valid, sel_valid;
    logic pattern_poly, pattern_commit;
    logic [3:0] panel_sel_chan = 0, panel_cc_chan = 0, rx_chan, tx_chan, tx_cc_chan, sel_chan;
    logic [6:0] panel_sel_bank = 0, panel_sel_prog = 0, panel_cc_num = 0, panel_cc_val = 0, rx_d1, rx_d2;
    logic [6:0] map_edit_idx = 0, map_edit_item = 0, user_pattern = 0, pattern_step_count = 7'h08;
    logic [6:0] panel_value = 0, tx_prog, tx_bank, tx_cc_num, tx_cc_val, sel_item, map_view_item, step_vel;
    logic [5:0] step_ptr;
    logic signed [6:0] step_note;
    logic [19:0] msg = 0, rx_msg;
    logic [15:0] s = 16'h6331;
    int error_cnt = 0, samples_checked = 0;
    pmp_pkg::pmp_cc_kind_t panel_cc_kind = pmp_pkg::PMP_CCK_PANEL;
    pmp_pkg::pmp_rx_kind_t rx_kind;
    pmp_pkg::pmp_pc_mode_t incoming_pc_mode = pmp_pkg::PMP_PC_ENABLED;
    pmp_pkg::pmp_target_t sel_target, map_view_target, map_edit_target = pmp_pkg::PMP_TGT_CURR;
    pmp_pkg::pmp_kpe_t keyboard_pattern_entry_mode = pmp_pkg::PMP_KPE_OFF;
    pmp_pkg::pmp_field_t panel_field = pmp_pkg::PMP_FLD_STEP;
    pmp_pkg::pmp_gate_t step_gate;
    pmp_midi_core dut (.*);
    pmp_kbd_model kbd (.go(go), .msg(msg), .rx_valid(rx_valid), .rx_msg(rx_msg));
    assign rx_kind = pmp_pkg::pmp_rx_kind_t'(rx_msg[19:18]);
    assign {rx_chan, rx_d1, rx_d2} = rx_msg[17:0];
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic check(logic [23:0] seen, logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        error_cnt += int'(seen !== exp);
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic send(logic [1:0] k, logic [3:0] c, logic [6:0] a, logic [6:0] b);
        @(negedge clk);
        msg = {k, c, a, b};
        go = 1;
        @(negedge clk);
        go = 0;
    endtask
    always #50 clk = ~clk;
    initial begin
        repeat (2) @(negedge clk);
        reset_n = 1;
        @(negedge clk);
        panel_sel_valid = 1;
        for (int i = 0; i < 8; i++) begin
            s = lfsr(s);
            {prog_tx_enable, panel_sel_chan, panel_sel_bank, panel_sel_prog} = {s[0], s[4:1], s[15:9], s[11:5]};
            @(negedge clk);
            check({tx_pc_valid, tx_bank_valid}, {2{prog_tx_enable}});
            if (prog_tx_enable)
                check({tx_chan, tx_prog, tx_bank}, {panel_sel_chan, panel_sel_prog, panel_sel_bank});
        end
        panel_sel_valid = 0;
        panel_cc_valid = 1;
        for (int i = 0; i < 6; i++) begin
            s = lfsr(s);
            {ctrl_tx_enable, panel_cc_chan, panel_cc_num, panel_cc_val} = {i[0], s[3:0], s[10:4], s[15:9]};
            panel_cc_kind = pmp_pkg::pmp_cc_kind_t'(i / 2);
            @(negedge clk);
            check(tx_cc_valid, ctrl_tx_enable | (i > 1));
            if (ctrl_tx_enable | (i > 1))
                check({tx_cc_chan, tx_cc_num, tx_cc_val}, {panel_cc_chan, panel_cc_num, panel_cc_val});
        end
        panel_cc_valid = 0;
        for (int i = 0; i < 5; i++) begin
            if (i > 0) send(2'd2, 4'h5, 7'h20, 7'(i % 4));
            repeat (2) begin
                s = lfsr(s);
                send(2'd3, 4'h5, s[6:0], 7'h00);
                check({sel_valid, sel_chan, sel_target, sel_item}, {1'b1, 4'h5, 3'(i % 4), s[6:0]});
            end
        end
        incoming_pc_mode = pmp_pkg::PMP_PC_MAP;
        send(2'd2, 4'h5, 7'h20, 7'h02);
        send(2'd3, 4'h5, s[13:7], 7'h00);
        check({sel_valid, sel_target, sel_item}, {4'h8, s[13:7]});
        incoming_pc_mode = pmp_pkg::PMP_PC_DISABLED;
        send(2'd3, 4'h5, s[13:7], 7'h00);
        check(sel_valid, 1'b0);
        pattern_page_active = 1;
        for (int i = 0; i < 2; i++) begin
            keyboard_pattern_entry_mode = pmp_pkg::pmp_kpe_t'(i);
            s = lfsr(s);
            send(2'd0, s[3:0], s[10:4], 7'h01 | s[15:9]);
            check({step_ptr, step_vel}, {6'd0, i ? (7'h01 | s[15:9]) : 7'h40});
            if (i) check(step_note, 7'(s[10:4] % 12 + 1));
            send(2'd1, s[3:0], s[10:4], 7'h00);
            check(step_ptr, 6'(i));
        end
        send(2'd2, 4'h9, 7'h40, 7'h7f);
        check(step_ptr, 6'd2);
        {panel_step_we, panel_value} = 8'h81;
        @(negedge clk);
        panel_step_we = 0;
        check(step_gate, pmp_pkg::PMP_GATE_REST);
        for (int i = 0; i < 4; i++) begin
            {map_page_active, memory_protect} = 2'(i);
            pattern_page_active = ~map_page_active;
            user_pattern = 7'h3f + 7'(i[1]);
            @(negedge clk);
            write_button = 1;
            @(negedge clk);
            write_button = 0;
            check(pattern_commit, i == 0);
            check(pattern_poly, i > 1);
        end
        map_edit_we = 1;
        for (int i = 0; i < 7; i++) begin
            s = lfsr(s);
            {map_edit_idx, map_edit_item} = s[13:0];
            map_edit_target = pmp_pkg::pmp_target_t'(i);
            @(negedge clk);
            check({map_view_target, map_view_item}, {3'(i), s[6:0]});
        end
        map_edit_we = 0;
        complete_run();
    end
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule // pmp_midi_core_tb_top
